// file: hdl/no_load_map.vh
// Register offsets, field positions and reset values of the no load block
`ifndef NO_LOAD_MAP_VH
`define NO_LOAD_MAP_VH

`define ADDR_ACTIVE_NO_LOAD_TIME   4'h0
`define ADDR_APPARENT_NO_LOAD_TIME 4'h1
`define ADDR_REACTIVE_NO_LOAD_TIME 4'h2
`define ADDR_PHASE_NO_LOAD_STATE   4'h3
`define ADDR_SECOND_EVENT_FLAGS    4'h4
`define ADDR_SECOND_EVENT_ENABLES  4'h5

`define FLAG_TOTAL       0
`define FLAG_FUND        1
`define FLAG_APPARENT    2
`define FIELD_TOTAL_LSB  0
`define FIELD_FUND_LSB   3
`define FIELD_APP_LSB    6

`define TIME_RESET       16'h0000
`define FLAGS_RESET      3'h0
`define ENABLES_RESET    3'h0

`endif

// file: hdl/no_load_timer.v
// One per-phase no load timer: a 16-bit counter with overflow detection
`timescale 1ns/1ps
module no_load_timer #(
  parameter WIDTH = 16
) (
  input  wire             ref_clk,   // Core clock
  input  wire             rstn,      // Async reset, active low
  input  wire             enable,    // Detector armed
  input  wire [WIDTH-1:0] load_val,  // Programmed time
  input  wire             acc_a,     // Energy LSB from first source
  input  wire             acc_b,     // Energy LSB from second source
  input  wire             use_a,     // First source counts
  input  wire             use_b,     // Second source counts
  output reg              no_load_q  // Phase in no load
);

  reg  [WIDTH-1:0] count_q;
  wire             hit;
  wire [WIDTH:0]   sum;

  assign hit = (acc_a & use_a) | (acc_b & use_b);
  assign sum = {1'b0, count_q} + {{WIDTH{1'b0}}, 1'b1};

  // Reload on accumulation, enter on overflow, leave on next accumulation
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count_q   <= {WIDTH{1'b0}};
      no_load_q <= 1'b0;
    end else if (!enable) begin
      count_q   <= load_val;
      no_load_q <= 1'b0;
    end else if (hit) begin
      count_q   <= load_val;
      no_load_q <= 1'b0;
    end else if (sum[WIDTH]) begin
      count_q   <= load_val;
      no_load_q <= 1'b1;
    end else begin
      count_q   <= sum[WIDTH-1:0];
    end
  end

endmodule // no_load_timer

// file: hdl/energy_no_load_detector.v
// Three-phase no load detectors with flags, enables and interrupt output
// Register map, one 16-bit word each
//   0 active no load time, read and write
//   1 apparent no load time, read and write
//   2 reactive no load time, read and write
//   3 phase no load state, read only
//   4 second event flags, write 1 to clear
//   5 second event enables, read and write
//   Other indices read zero, writes dropped
//
// Register bus
//   Write: one cycle strobe with index and data
//   Read: one cycle strobe, data in the next cycle only
//   Read data back to zero outside that cycle
//   No wait states, strobes may follow back to back
//
// Phase state layout
//   Bits [2:0] total detector, phase A lowest
//   Bits [5:3] fundamental detector
//   Bits [8:6] apparent detector
//   Bits [15:9] always zero
//
// Flag and enable layout
//   Bit 0 total, bit 1 fundamental, bit 2 apparent
//   Flags set on entry and on exit alike
//   Set beats a clear in the same cycle
//
// Detector timing
//   Counter loaded with the programmed time
//   Counts up on each cycle without a qualifying LSB
//   No load once it wraps past all ones
//   A qualifying LSB reloads and leaves no load next edge
//   Flag and visible state bits one edge after the timer
//   Accumulation gate one edge after the timer too
//   Interrupt low on the edge the enabled flag sets
//
// Criterion selection
//   Total: active time, else apparent time if active is zero
//   Total: off only with both times zero
//   Fundamental: active time, else reactive time
//   Fundamental: off only with active and reactive zero
//   Apparent: own time, off when zero
//   Disabling a detector counts as an exit event
//
// Reset
//   All times zero, so every detector starts disabled
//   Gates open, interrupt high, flags and enables clear
//
// Limitations and hazards
//   One counter per criterion pair, so with both times set
//   the active time is the load; unequal values not honoured
//   All-ones times are not guarded in hardware
//   A new time loads at the next reload, not at once
//   LSB inputs must be one-cycle pulses of this clock
//   A mid-run reset drops all state and programmed times
//
`timescale 1ns/1ps
`include "no_load_map.vh"
module energy_no_load_detector #(
  parameter PHASES = 3,
  parameter TW     = 16
) (
  input  wire              ref_clk,            // 20 MHz core clock
  input  wire              rstn,               // Async reset, active low
  input  wire [3:0]        addr,               // Register index
  input  wire [15:0]       wdata,              // Write data
  input  wire              wr,                 // Write strobe
  input  wire              rd,                 // Read strobe
  output reg  [15:0]       rdata_q,            // Read data, cycle after rd
  input  wire [PHASES-1:0] active_lsb,         // Total active energy LSB
  input  wire [PHASES-1:0] apparent_lsb,       // Apparent energy LSB
  input  wire [PHASES-1:0] fund_active_lsb,    // Fundamental active LSB
  input  wire [PHASES-1:0] fund_reactive_lsb,  // Fundamental reactive LSB
  output reg  [PHASES-1:0] active_acc_en_q,    // Total active may accumulate
  output reg  [PHASES-1:0] fund_acc_en_q,      // Fundamental may accumulate
  output reg  [PHASES-1:0] apparent_acc_en_q,  // Apparent may accumulate
  output reg               second_interrupt_out_n_q // Interrupt, active low
);

  reg  [TW-1:0] active_no_load_time_q;
  reg  [TW-1:0] apparent_no_load_time_q;
  reg  [TW-1:0] reactive_no_load_time_q;
  reg  [2:0]    second_event_flags_q;
  reg  [2:0]    second_event_enables_q;
  reg  [PHASES-1:0] total_prev_q;
  reg  [PHASES-1:0] fund_prev_q;
  reg  [PHASES-1:0] app_prev_q;

  wire [PHASES-1:0] total_noload_phase_bits;
  wire [PHASES-1:0] fundamental_noload_phase_bits;
  wire [PHASES-1:0] apparent_noload_phase_bits;

  wire ap_zero;
  wire va_zero;
  wire var_zero;
  wire total_en;
  wire fund_en;
  wire app_en;
  wire [2:0] change;
  wire [2:0] clear_req;
  wire [2:0] flags_d;
  wire [15:0] phase_no_load_state;
  wire [TW-1:0] total_load_val;
  wire [TW-1:0] fund_load_val;

  // Zero times switch criteria off
  assign ap_zero  = (active_no_load_time_q == 16'h0000);
  assign va_zero  = (apparent_no_load_time_q == 16'h0000);
  assign var_zero = (reactive_no_load_time_q == 16'h0000);
  assign total_en = ~(ap_zero & va_zero);
  assign fund_en  = ~(ap_zero & var_zero);
  assign app_en   = ~va_zero;

  // Load values: active time first, the other one if active is zero
  assign total_load_val = ap_zero ? apparent_no_load_time_q
                                  : active_no_load_time_q;
  assign fund_load_val  = ap_zero ? reactive_no_load_time_q
                                  : active_no_load_time_q;

  // Total detector: one timer per phase, the time used is the active one
  // unless zero, then the apparent one. Both criteria share one counter,
  // which keeps area small; with both set the values are normally equal.
  genvar g;
  generate
    for (g = 0; g < PHASES; g = g + 1) begin : g_phase
      no_load_timer #(.WIDTH(TW)) u_total (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .enable    (total_en),
        .load_val  (total_load_val),
        .acc_a     (active_lsb[g]),
        .acc_b     (apparent_lsb[g]),
        .use_a     (~ap_zero),
        .use_b     (~va_zero),
        .no_load_q (total_noload_phase_bits[g])
      );
      // Fundamental: active and reactive both quiet
      no_load_timer #(.WIDTH(TW)) u_fund (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .enable    (fund_en),
        .load_val  (fund_load_val),
        .acc_a     (fund_active_lsb[g]),
        .acc_b     (fund_reactive_lsb[g]),
        .use_a     (~ap_zero),
        .use_b     (~var_zero),
        .no_load_q (fundamental_noload_phase_bits[g])
      );
      no_load_timer #(.WIDTH(TW)) u_app (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .enable    (app_en),
        .load_val  (apparent_no_load_time_q),
        .acc_a     (apparent_lsb[g]),
        .acc_b     (1'b0),
        .use_a     (1'b1),
        .use_b     (1'b0),
        .no_load_q (apparent_noload_phase_bits[g])
      );
    end
  endgenerate

  // Entry or exit of any phase raises the matching event
  assign change[`FLAG_TOTAL]    = |(total_noload_phase_bits ^ total_prev_q);
  assign change[`FLAG_FUND]     =
    |(fundamental_noload_phase_bits ^ fund_prev_q);
  assign change[`FLAG_APPARENT] = |(apparent_noload_phase_bits ^ app_prev_q);

  assign clear_req = (wr && addr == `ADDR_SECOND_EVENT_FLAGS) ?
                     wdata[2:0] : 3'h0;
  // Set beats clear so an event in the clear cycle is kept
  assign flags_d = (second_event_flags_q & ~clear_req) | change;

  // State bits come from the history, so they move with the flags
  assign phase_no_load_state = {7'h00,
    app_prev_q,
    fund_prev_q,
    total_prev_q};

  // Total detector history, one edge behind its timers
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      total_prev_q <= {PHASES{1'b0}};
    end else begin
      total_prev_q <= total_noload_phase_bits;
    end
  end

  // Fundamental detector history
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fund_prev_q <= {PHASES{1'b0}};
    end else begin
      fund_prev_q <= fundamental_noload_phase_bits;
    end
  end

  // Apparent detector history
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      app_prev_q <= {PHASES{1'b0}};
    end else begin
      app_prev_q <= apparent_noload_phase_bits;
    end
  end

  // Sticky flags, set whatever the enables say
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      second_event_flags_q <= `FLAGS_RESET;
    end else begin
      second_event_flags_q <= flags_d;
    end
  end

  // Interrupt low while any enabled flag stands, high once cleared
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      second_interrupt_out_n_q <= 1'b1;
    end else begin
      second_interrupt_out_n_q <=
        ~|(flags_d & second_event_enables_q);
    end
  end

  // Total active gate follows the total state of each phase
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      active_acc_en_q <= {PHASES{1'b1}};
    end else begin
      active_acc_en_q <= ~total_noload_phase_bits;
    end
  end

  // Fundamental gate covers active and reactive together
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fund_acc_en_q <= {PHASES{1'b1}};
    end else begin
      fund_acc_en_q <= ~fundamental_noload_phase_bits;
    end
  end

  // Apparent gate follows the apparent state
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      apparent_acc_en_q <= {PHASES{1'b1}};
    end else begin
      apparent_acc_en_q <= ~apparent_noload_phase_bits;
    end
  end

  // Register writes; software keeps times off all ones
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      active_no_load_time_q   <= `TIME_RESET;
      apparent_no_load_time_q <= `TIME_RESET;
      reactive_no_load_time_q <= `TIME_RESET;
      second_event_enables_q  <= `ENABLES_RESET;
    end else if (wr) begin
      case (addr)
        `ADDR_ACTIVE_NO_LOAD_TIME: begin
          active_no_load_time_q <= wdata;
        end
        `ADDR_APPARENT_NO_LOAD_TIME: begin
          apparent_no_load_time_q <= wdata;
        end
        `ADDR_REACTIVE_NO_LOAD_TIME: begin
          reactive_no_load_time_q <= wdata;
        end
        `ADDR_SECOND_EVENT_ENABLES: begin
          second_event_enables_q <= wdata[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `ADDR_ACTIVE_NO_LOAD_TIME: begin
          rdata_q <= active_no_load_time_q;
        end
        `ADDR_APPARENT_NO_LOAD_TIME: begin
          rdata_q <= apparent_no_load_time_q;
        end
        `ADDR_REACTIVE_NO_LOAD_TIME: begin
          rdata_q <= reactive_no_load_time_q;
        end
        `ADDR_PHASE_NO_LOAD_STATE: begin
          rdata_q <= phase_no_load_state;
        end
        `ADDR_SECOND_EVENT_FLAGS: begin
          rdata_q <= {13'h0000, second_event_flags_q};
        end
        `ADDR_SECOND_EVENT_ENABLES: begin
          rdata_q <= {13'h0000, second_event_enables_q};
        end
        default: begin
          rdata_q <= 16'h0000;
        end
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

endmodule // energy_no_load_detector

// file: verification/no_load_monitor.sv
// Port-level assertions for the energy no load detector
`timescale 1ns/1ps
module no_load_monitor #(
  parameter PHASES = 3
) (
  input wire              ref_clk,                  // Clock
  input wire              rstn,                     // Reset, low
  input wire [3:0]        addr,                     // Index
  input wire [15:0]       wdata,                    // Write data
  input wire              wr,                       // Write
  input wire              rd,                       // Read
  input wire [15:0]       rdata_q,                  // Read data
  input wire [PHASES-1:0] active_lsb,               // Active LSB
  input wire [PHASES-1:0] apparent_lsb,             // Apparent LSB
  input wire [PHASES-1:0] fund_active_lsb,          // Fund active LSB
  input wire [PHASES-1:0] fund_reactive_lsb,        // Fund reactive LSB
  input wire [PHASES-1:0] active_acc_en_q,          // Active enable
  input wire [PHASES-1:0] fund_acc_en_q,            // Fund enable
  input wire [PHASES-1:0] apparent_acc_en_q,        // Apparent enable
  input wire              second_interrupt_out_n_q  // Interrupt
);
  reg [15:0] act_q;
  reg [15:0] app_q;
  reg [2:0]  en_q;
  // Shadow of written registers, no wait states on the bus
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      act_q <= 16'h0000;
      app_q <= 16'h0000;
      en_q  <= 3'h0;
    end else if (wr) begin
      if (addr == 4'h0) act_q <= wdata;
      if (addr == 4'h1) app_q <= wdata;
      if (addr == 4'h5) en_q <= wdata[2:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_read_idle_zero: assert property (
    !$past(rd) |-> rdata_q == 16'h0000)
    else $error("read data not zero outside read cycle");
  a_unmapped_read: assert property (
    $past(rd) && $past(addr) > 4'h5 |-> rdata_q == 16'h0000)
    else $error("unmapped read not zero");
  a_enable_readback: assert property (
    $past(rd) && $past(addr) == 4'h5 |-> rdata_q == {13'h0000, en_q})
    else $error("enables read back wrong");
  a_time_readback: assert property (
    $past(rd) && $past(addr) == 4'h0 |-> rdata_q == act_q)
    else $error("active time read back wrong");
  a_irq_masked_high: assert property (
    en_q == 3'h0 [*3] |-> second_interrupt_out_n_q)
    else $error("interrupt low with all enables off");
  a_total_off: assert property (
    act_q == 16'h0000 && app_q == 16'h0000 [*3]
    |-> active_acc_en_q == 3'h7)
    else $error("total detector blocks while off");
  a_apparent_off: assert property (
    app_q == 16'h0000 [*3] |-> apparent_acc_en_q == 3'h7)
    else $error("apparent detector blocks while off");
  a_apparent_unblock: assert property (
    apparent_lsb[0] |-> ##2 apparent_acc_en_q[0])
    else $error("apparent LSB did not unblock phase A");
  a_fund_unblock: assert property (
    fund_active_lsb[0] && act_q != 16'h0000 |-> ##2 fund_acc_en_q[0])
    else $error("fundamental LSB did not unblock phase A");
endmodule // no_load_monitor

bind energy_no_load_detector no_load_monitor #(.PHASES(PHASES)) i_mon (
  .ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata_q(rdata_q), .active_lsb(active_lsb),
  .apparent_lsb(apparent_lsb), .fund_active_lsb(fund_active_lsb),
  .fund_reactive_lsb(fund_reactive_lsb), .active_acc_en_q(active_acc_en_q),
  .fund_acc_en_q(fund_acc_en_q), .apparent_acc_en_q(apparent_acc_en_q),
  .second_interrupt_out_n_q(second_interrupt_out_n_q));

// file: verification/energy_no_load_detector_tb.sv
// Self-checking bench for the energy no load detector
`timescale 1ns/1ps
module energy_no_load_detector_tb;
  reg         ref_clk = 1'b0;
  reg         rstn = 1'b0;
  reg  [3:0]  addr = 4'h0;
  reg  [15:0] wdata = 16'h0000;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  reg  [2:0]  feed = 3'h7;
  wire [15:0] rdata_q;
  wire [2:0]  act_en;
  wire [2:0]  fund_en;
  wire [2:0]  app_en;
  wire        irq_n;
  integer     fail_count = 0;
  integer     n_compared = 0;
  integer     i;
  // Same LSB pattern on every energy source keeps stimulus short
  energy_no_load_detector i_dut (
    .ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_q(rdata_q), .active_lsb(feed), .apparent_lsb(feed),
    .fund_active_lsb(feed), .fund_reactive_lsb(feed),
    .active_acc_en_q(act_en), .fund_acc_en_q(fund_en),
    .apparent_acc_en_q(app_en), .second_interrupt_out_n_q(irq_n));
  // Clock, 50 ns period
  always #25 ref_clk = ~ref_clk;
  task check(input string name, input logic [15:0] seen, exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wr_reg(input [3:0] a, input [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task rd_chk(input [3:0] a, input [15:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    check($sformatf("reg%0h", a), rdata_q, exp);
  endtask
  // Outputs are looked at after the edge's updates have settled
  task out_chk(input [2:0] ea, ef, ep, input ei);
    #1;
    check("act_en", {13'h0000, act_en}, {13'h0000, ea});
    check("fund_en", {13'h0000, fund_en}, {13'h0000, ef});
    check("app_en", {13'h0000, app_en}, {13'h0000, ep});
    check("irq_n", {15'h0000, irq_n}, {15'h0000, ei});
  endtask
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog well beyond the expected run of a few hundred cycles
  initial begin
    #(50 * 3000);
    fail_count = fail_count + 1;
    tally_and_finish;
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    for (i = 0; i < 8; i = i + 1)
      rd_chk(i[3:0], 16'h0000);
    out_chk(3'h7, 3'h7, 3'h7, 1'b1);
    $display("test reset done");
    // Phase A starves, active time only
    wr_reg(4'h5, 16'h0001);
    wr_reg(4'h0, 16'hFFF0);
    rd_chk(4'h0, 16'hFFF0);
    feed <= 3'h6;
    repeat (40) @(posedge ref_clk);
    out_chk(3'h6, 3'h6, 3'h7, 1'b0);
    rd_chk(4'h4, 16'h0003);
    rd_chk(4'h3, 16'h0009);
    wr_reg(4'h4, 16'h0001);
    rd_chk(4'h4, 16'h0002);
    check("irq_n", {15'h0000, irq_n}, 16'h0001);
    wr_reg(4'h4, 16'h0002);
    feed <= 3'h7;
    repeat (5) @(posedge ref_clk);
    out_chk(3'h7, 3'h7, 3'h7, 1'b0);
    rd_chk(4'h3, 16'h0000);
    rd_chk(4'h4, 16'h0003);
    $display("test total done");
    // Apparent criterion alone, phase C starves
    wr_reg(4'h1, 16'hFFF0);
    wr_reg(4'h0, 16'h0000);
    wr_reg(4'h4, 16'h0007);
    wr_reg(4'h5, 16'h0004);
    feed <= 3'h3;
    repeat (40) @(posedge ref_clk);
    out_chk(3'h3, 3'h7, 3'h3, 1'b0);
    rd_chk(4'h3, 16'h0104);
    wr_reg(4'h5, 16'h0000);
    repeat (2) @(posedge ref_clk);
    #1;
    check("irq_n", {15'h0000, irq_n}, 16'h0001);
    rd_chk(4'h4, 16'h0005);
    $display("test apparent done");
    // Reactive criterion alone, phase B starves
    feed <= 3'h7;
    repeat (5) @(posedge ref_clk);
    wr_reg(4'h1, 16'h0000);
    wr_reg(4'h2, 16'hFFF0);
    wr_reg(4'h4, 16'h0007);
    feed <= 3'h5;
    repeat (40) @(posedge ref_clk);
    out_chk(3'h7, 3'h5, 3'h7, 1'b1);
    wr_reg(4'h4, 16'h0000);
    rd_chk(4'h4, 16'h0002);
    wr_reg(4'h3, 16'hFFFF);
    rd_chk(4'h3, 16'h0010);
    rd_chk(4'h2, 16'hFFF0);
    $display("test fundamental done");
    tally_and_finish;
  end
endmodule // energy_no_load_detector_tb
